// *** logic/adc_seq_pkg.sv ***
package adc_seq_pkg;
  // ------------------------------------------------------------
  // register map (apb byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] SELECT_OFFSET = 12'h008;
  localparam logic [11:0] RESULT_OFFSET = 12'h00c;
  localparam logic [11:0] CMP_OFFSET = 12'h010;
  // ------------------------------------------------------------
  // control word layout
  // ------------------------------------------------------------
  localparam int CTRL_W = 10;
  localparam int PKG_ADDR_BIT = 9;
  localparam int PD_HI_BIT = 8;
  localparam int PD_LO_BIT = 7;
  localparam int COMMON_REF_BIT = 6;
  localparam int PAIR_MODE_BIT = 5;
  localparam int CH_LSB = 2;
  localparam int SW_CONV_BIT = 1;
  localparam int EXT_REF_BIT = 0;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  // ------------------------------------------------------------
  // selection codes
  // ------------------------------------------------------------
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_HALF_REF = 4'h9;
  localparam logic [3:0] SEL_FULL_REF = 4'ha;
  localparam logic [3:0] NEG_AGND = 4'h0;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_NS = 100;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RES_W = 10;
  typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_DONE} phase_t;
endpackage : adc_seq_pkg

// *** logic/adc_channel_select_sequencer.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - sgl, common off: input channel+1 vs ground
// RULE_02 - common on: inputs 1-7 against input 8
// RULE_03 - pair mode: pairs 1/2..7/8, odd positive
// RULE_04 - pair codes 4/5: half/full reference test
// RULE_05 - acquire after conversion; convert on start falling
// RULE_06 - host waits 100 ns before start low
// RULE_07 - single-ended: sample reference side to ground
// RULE_08 - pseudo-differential: reference side to negative input
// RULE_09 - step search until balanced, then complete
// RULE_10 - package address bit clears at reset
// RULE_11 - ten bit write-only control word layout
// RULE_12 - drop words whose address mismatches strap
// RULE_13 - common bit ignored in pair mode
// RULE_14 - host avoids pair codes 6 and 7
module adc_channel_select_sequencer
  import adc_seq_pkg::*;
#(
  parameter int RESULT_W = RES_W
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // pins
  input wire logic convert_start_n_i,
  input wire logic package_address_i,
  input wire logic comparator_i,
  // analog switch controls
  output logic [3:0] pos_sel_o,
  output logic [3:0] neg_sel_o,
  output logic sample_o,
  output logic [RESULT_W-1:0] dac_code_o,
  output logic conv_done_o
);
  typedef struct packed {
    logic [2:0] cvs;
    logic cv_lvl;
    logic [2:0] pas;
    logic strap;
    logic [CTRL_W-1:0] ctrl;
    phase_t phase;
    logic [RESULT_W-1:0] sar;
    logic [RESULT_W-1:0] bitm;
    logic [RESULT_W-1:0] result;
    logic [3:0] pos;
    logic [3:0] neg;
    logic sample;
    logic done;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;
  state_t s_r;
  state_t s_nxt;
  // ------------------------------------------------------------
  // input selection decode
  // ------------------------------------------------------------
  function automatic logic [7:0] decode_sel(input logic [CTRL_W-1:0] c);
    logic [2:0] ch;
    logic [3:0] p;
    logic [3:0] n;
    ch = c[CH_LSB+:3];
    p = SEL_NONE;
    n = NEG_AGND;
    if (c[PAIR_MODE_BIT]) begin // RULE_13
      unique case (ch)
        3'h0, 3'h1, 3'h2, 3'h3: begin // RULE_03
          p = 4'({ch[1:0], 1'b0}) + 4'h1;
          n = 4'({ch[1:0], 1'b0}) + 4'h2;
        end
        3'h4: p = SEL_HALF_REF; // RULE_04
        3'h5: p = SEL_FULL_REF; // RULE_04
        default: p = SEL_NONE;
      endcase
    end else if (c[COMMON_REF_BIT]) begin
      // code 7 would select input 8 against itself; left unconnected
      if (ch != 3'h7) begin
        p = 4'(ch) + 4'h1; // RULE_02
        n = 4'h8; // RULE_02
      end
    end else begin
      p = 4'(ch) + 4'h1; // RULE_01
    end
    decode_sel = {p, n};
  endfunction : decode_sel

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] sel;
    logic acc;
    logic start_fall;
    logic sw_go;
    sel = decode_sel(s_r.ctrl);
    // a request is taken once; the pulse on pready closes it
    acc = psel_i & penable_i & ~s_r.pready;
    // only the second and third stages are looked at, never the first
    start_fall = s_r.cv_lvl & ~s_r.cvs[2] & ~s_r.cvs[1];
    sw_go = s_r.ctrl[SW_CONV_BIT];
    s_nxt = s_r;
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    s_nxt.cvs = {s_r.cvs[1:0], convert_start_n_i};
    s_nxt.pas = {s_r.pas[1:0], package_address_i};
    // a level counts only once two stages agree, so a glitch never starts a conversion
    if (s_r.cvs[2] == s_r.cvs[1]) begin
      s_nxt.cv_lvl = s_r.cvs[2];
    end
    if (s_r.pas[2] == s_r.pas[1]) begin
      s_nxt.strap = s_r.pas[2];
    end
    // ------------------------------------------------------------
    // phase sequencing
    // ------------------------------------------------------------
    s_nxt.done = 1'b0;
    s_nxt.pos = sel[7:4];
    s_nxt.pready = acc;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = '0;
    unique case (s_r.phase)
      ST_ACQ: begin
        // a start edge seen outside acquisition is dropped, not queued
        s_nxt.sample = 1'b1;
        s_nxt.neg = sel[3:0];
        if (start_fall || sw_go) begin // RULE_05
          s_nxt.phase = ST_CONV;
          s_nxt.sample = 1'b0;
          s_nxt.neg = sel[3:0]; // RULE_07 RULE_08
          s_nxt.bitm = {1'b1, {(RESULT_W-1){1'b0}}};
          s_nxt.sar = {1'b1, {(RESULT_W-1){1'b0}}};
        end
      end
      ST_CONV: begin
        // comparator high means the trial code overshot the sample
        logic [RESULT_W-1:0] kept;
        kept = comparator_i ? (s_r.sar & ~s_r.bitm) : s_r.sar; // RULE_09
        s_nxt.bitm = s_r.bitm >> 1;
        if (s_r.bitm[0]) begin
          s_nxt.result = kept; // RULE_09
          s_nxt.sar = kept;
          s_nxt.phase = ST_DONE;
          s_nxt.done = 1'b1;
          s_nxt.ctrl[SW_CONV_BIT] = 1'b0;
        end else begin
          s_nxt.sar = kept | (s_r.bitm >> 1);
        end
      end
      ST_DONE: begin
        s_nxt.phase = ST_ACQ; // RULE_05
        s_nxt.sample = 1'b1;
      end
    endcase
    // ------------------------------------------------------------
    // apb access
    // ------------------------------------------------------------
    if (acc) begin
      if (pwrite_i) begin
        unique case (paddr_i)
          CTRL_OFFSET: begin
            if (pwdata_i[PKG_ADDR_BIT] == s_r.strap) begin // RULE_12
              s_nxt.ctrl = pwdata_i[CTRL_W-1:0]; // RULE_11
            end
          end
          STATUS_OFFSET, SELECT_OFFSET, RESULT_OFFSET: ;
          default: s_nxt.pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr_i)
          CTRL_OFFSET: s_nxt.prdata = '0;
          STATUS_OFFSET: s_nxt.prdata = {29'h0, s_r.strap, 2'(s_r.phase)};
          SELECT_OFFSET: s_nxt.prdata = {24'h0, s_r.pos, s_r.neg};
          RESULT_OFFSET: s_nxt.prdata = 32'(s_r.result);
          default: s_nxt.pslverr = 1'b1;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '0; // RULE_10
      // the start synchroniser starts at the idle pin level, so no false edge follows reset
      s_r.cvs <= 3'h7;
      s_r.cv_lvl <= 1'b1;
      s_r.ctrl <= CTRL_RESET; // RULE_10
      s_r.phase <= ST_ACQ;
      s_r.sample <= 1'b1;
    end else if (clk_en_i) begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata_o = s_r.prdata;
  assign pready_o = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign pos_sel_o = s_r.pos;
  assign neg_sel_o = s_r.neg;
  assign sample_o = s_r.sample;
  assign dac_code_o = s_r.sar;
  assign conv_done_o = s_r.done;
endmodule : adc_channel_select_sequencer

// *** testbench/adc_seq_checker_asserts.sv ***
`timescale 1ns/1ps
module adc_seq_checker
  import adc_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic convert_start_n_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sample_o,
  input wire logic conv_done_o,
  input wire logic [3:0] pos_sel_o,
  input wire logic [3:0] neg_sel_o
);
  // ----------------------------------------
  // timing and selection checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i || !clk_en_i);
  apb_wait_state_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready late");
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready held");
  err_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("pslverr alone");
  done_pulse_a: assert property (conv_done_o |=> !conv_done_o) else $error("done held");
  acq_restart_a: assert property (conv_done_o |-> ##[0:2] sample_o)
    else $error("no acquire after done");
  conv_start_a: assert property ($fell(convert_start_n_i) && sample_o |-> ##[2:7] !sample_o)
    else $error("start edge ignored");
  conv_length_a: assert property ($fell(sample_o) |-> ##[9:12] conv_done_o)
    else $error("conversion length");
  // common input 8 is excluded: it pairs with any positive input
  pair_order_a: assert property (neg_sel_o != NEG_AGND && neg_sel_o != 4'h8
    |-> pos_sel_o + 4'h1 == neg_sel_o) else $error("pair order");
  cover property (conv_done_o);
  cover property (pslverr_o);
  cover property (pos_sel_o == SEL_FULL_REF);
endmodule : adc_seq_checker
bind adc_channel_select_sequencer adc_seq_checker u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .clk_en_i(clk_en_i),
  .psel_i(psel_i), .penable_i(penable_i), .convert_start_n_i(convert_start_n_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_o(sample_o),
  .conv_done_o(conv_done_o), .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o));

// *** testbench/adc_comparator_model.sv ***
`timescale 1ns/1ps
module adc_comparator_model (
  input wire logic [9:0] dac_code_i,
  input wire logic [9:0] level_i,
  output logic comparator_o
);
  // high while the trial code lies above the held input level
  assign comparator_o = dac_code_i > level_i;
endmodule : adc_comparator_model

// *** testbench/tb_adc_channel_select_sequencer.sv ***
`timescale 1ns/1ps
module tb_adc_channel_select_sequencer;
  import adc_seq_pkg::*;
  logic clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0, start_n = 1, strap = 0, cmp;
  logic run = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata_o, c, r;
  logic pready_o, pslverr_o, sample_o, conv_done_o, e;
  logic [3:0] pos_sel_o, neg_sel_o, ep, en;
  logic [9:0] dac_code_o, level = 10'h000;
  int errors = 0, n_compared = 0;
  adc_channel_select_sequencer u_dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(run),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .convert_start_n_i(start_n), .package_address_i(strap), .comparator_i(cmp),
    .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o), .sample_o(sample_o),
    .dac_code_o(dac_code_o), .conv_done_o(conv_done_o));
  adc_comparator_model u_cmp (.dac_code_i(dac_code_o), .level_i(level), .comparator_o(cmp));
  initial forever #10 clk_i = ~clk_i;
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // bit 1 of the word picks the software start instead of the pin
  task automatic conv(input logic [31:0] w, input logic [9:0] t, input logic [3:0] neg);
    level <= t;
    repeat (6) @(posedge clk_i);
    if (w[SW_CONV_BIT]) apb(1, CTRL_OFFSET, w);
    else start_n <= 0;
    do @(posedge clk_i); while (sample_o !== 1'b0);
    chk(neg_sel_o, neg);
    do @(posedge clk_i); while (conv_done_o !== 1'b1);
    chk(dac_code_o, t);
    start_n <= 1;
  endtask : conv
  task automatic summarize;
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    errors++;
    summarize();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 0;
    repeat (4) @(posedge clk_i);
    apb(0, SELECT_OFFSET, 32'h0);
    chk(r, 32'h10);
    for (int m = 0; m < 3; m++) for (int ch = 0; ch < 8; ch++) begin
      if ((m == 1 && ch == 7) || (m == 2 && ch > 5)) continue;
      c = (m == 1 || (m == 2 && ch % 2 == 1)) << 6 | (m == 2) << 5 | ch << 2;
      ep = m < 2 ? 4'(ch + 1) : ch < 4 ? 4'(2 * ch + 1) : ch == 4 ? SEL_HALF_REF : SEL_FULL_REF;
      en = m == 0 ? NEG_AGND : m == 1 ? 4'h8 : 4'(2 * ch + 2);
      apb(1, CTRL_OFFSET, c);
      apb(0, SELECT_OFFSET, 32'h0);
      chk(r[7:4], ep);
      if (m < 2 || ch < 4) chk(r[3:0], en);
    end
    apb(1, CTRL_OFFSET, 32'h20c);
    apb(0, SELECT_OFFSET, 32'h0);
    chk(r[7:4], SEL_FULL_REF);
    apb(0, CTRL_OFFSET, 32'h0);
    chk(r, 32'h0);
    apb(0, CMP_OFFSET, 32'h0);
    chk(e, 1'b1);
    strap <= 1;
    repeat (4) @(posedge clk_i);
    apb(1, CTRL_OFFSET, 32'h208);
    apb(0, SELECT_OFFSET, 32'h0);
    chk(r[7:4], 4'h3);
    strap <= 0;
    repeat (4) @(posedge clk_i);
    apb(1, CTRL_OFFSET, 32'h20);
    conv(32'h20, 10'h2a5, 4'h2);
    conv(32'h2, 10'h3ff, NEG_AGND);
    conv(32'h0, 10'h001, NEG_AGND);
    // a start pulse while frozen must leave the block in acquisition
    repeat (6) @(posedge clk_i);
    run <= 0;
    @(posedge clk_i);
    start_n <= 0;
    repeat (6) @(posedge clk_i);
    start_n <= 1;
    @(posedge clk_i);
    run <= 1;
    repeat (2) @(posedge clk_i);
    chk(sample_o, 1'b1);
    summarize();
  end
endmodule : tb_adc_channel_select_sequencer
